/* File: rtl/fsc_pkg.sv */
// fsc_pkg: constants of the flash status/control register bank.
// assumes: shared by the bank and its bench; no logic here.
package fsc_pkg;

	// ------------------------------------------------------------
	// serial commands
	// ------------------------------------------------------------
	localparam logic [7:0] FSC_OP_RD_GENERIC = 8'h65;
	localparam logic [7:0] FSC_OP_WR_GENERIC = 8'h71;
	localparam logic [7:0] FSC_OP_RD_STATUS1 = 8'h05;
	localparam logic [7:0] FSC_OP_WR_STATUS = 8'h31;

	// ------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] FSC_ADDR_VOL_RSVD = 8'h00;
	localparam logic [7:0] FSC_ADDR_STATUS1 = 8'h01;
	localparam logic [7:0] FSC_ADDR_STATUS2 = 8'h02;
	localparam logic [7:0] FSC_ADDR_CTRL3 = 8'h03;
	localparam logic [7:0] FSC_ADDR_CTRL4 = 8'h04;
	localparam logic [7:0] FSC_ADDR_NV_RSVD = 8'h80;
	localparam logic [7:0] FSC_ADDR_DRIVE = 8'h81;
	localparam int FSC_ADDR_NV_BIT = 7;

	// ------------------------------------------------------------
	// primary status byte fields
	// ------------------------------------------------------------
	localparam int FSC_B1_LOCK = 7;
	localparam int FSC_B1_DEEP = 6;
	localparam int FSC_B1_FAULT = 5;
	localparam int FSC_B1_DEEPEST = 4;
	localparam int FSC_B1_SUM_HI = 3;
	localparam int FSC_B1_SUM_LO = 2;
	localparam int FSC_B1_WPL = 1;
	localparam int FSC_B1_BUSY = 0;
	localparam logic [7:0] FSC_B1_DEEPEST_VAL = 8'hFF;
	localparam logic FSC_LOCK_RST = 1'b0;
	localparam logic [7:0] FSC_ZERO_BYTE = 8'h00;

	// ------------------------------------------------------------
	// reset values of the bytes whose layout is held elsewhere
	// ------------------------------------------------------------
	localparam logic [7:0] FSC_STATUS2_RST = 8'h00;
	localparam logic [7:0] FSC_CTRL3_RST = 8'h00;
	localparam logic [7:0] FSC_CTRL4_RST = 8'h00;
	localparam logic [7:0] FSC_DRIVE_RST = 8'h00;

	// ------------------------------------------------------------
	// command phases of one frame
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		FSC_PH_OPC = 3'b001,
		FSC_PH_ADR = 3'b010,
		FSC_PH_DAT = 3'b100
	} fsc_phase_t;

	localparam logic [2:0] FSC_BIT_LAST = 3'h7;
	localparam logic [2:0] FSC_BIT_FIRST = 3'h0;

endpackage : fsc_pkg

/* File: rtl/fsc_regs.sv */
// fsc_regs: status and control register bank behind the serial command port.
// assumes: link_clk is the serial clock (mode 0), running only inside frames;
// device status arrives on core_clk; write protect comes from a pin.
`timescale 1ns/1ps
`default_nettype none

module fsc_regs (
	// core side
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic power_up_rst_b,
	// device state
	input wire logic write_permit_latch,
	input wire logic operation_in_progress,
	input wire logic deep_sleep_mode,
	input wire logic deepest_sleep_mode,
	input wire logic [1:0] protection_summary,
	input wire logic pe_done,
	input wire logic pe_error,
	input wire logic auto_deepest_entry,
	// pin
	input wire logic wp_n,
	// serial link
	input wire logic link_clk,
	input wire logic link_cs_n,
	input wire logic link_mosi,
	output logic link_miso,
	output logic link_miso_oe,
	// register contents
	output logic protection_map_lock,
	output logic program_erase_fault,
	output logic [7:0] secondary_status_byte,
	output logic [7:0] third_status_control_byte,
	output logic [7:0] fourth_status_control_byte,
	output logic [7:0] output_drive_strength,
	output logic status_write_done
);
	import fsc_pkg::*;

	// ------------------------------------------------------------
	// link domain: command capture
	// ------------------------------------------------------------
	logic [2:0] bit_cnt_ff;
	logic [6:0] shift_ff;
	fsc_phase_t phase_ff;
	logic [7:0] opcode_ff;
	logic [7:0] addr_ff;
	logic start_nv_ff;
	logic wr_tgl_ff;
	logic [7:0] wr_addr_ff;
	logic [7:0] wr_data_ff;
	logic wr_nv_ff;
	logic [7:0] tx_ff;
	logic miso_ff;
	logic miso_oe_ff;

	wire [7:0] rx_byte = {shift_ff, link_mosi};
	wire byte_end = (bit_cnt_ff == FSC_BIT_LAST);
	wire op_is_wr = (opcode_ff == FSC_OP_WR_GENERIC) || (opcode_ff == FSC_OP_WR_STATUS);
	wire op_is_rd = (opcode_ff == FSC_OP_RD_GENERIC) || (opcode_ff == FSC_OP_RD_STATUS1);
	wire rx_legacy = (rx_byte == FSC_OP_RD_STATUS1) || (rx_byte == FSC_OP_WR_STATUS);
	wire in_data = (phase_ff == FSC_PH_DAT);
	wire data_byte_end = byte_end && in_data;
	// legacy 05h keeps returning the primary byte
	wire addr_hold = (opcode_ff == FSC_OP_RD_STATUS1);
	wire [7:0] addr_next = addr_hold ? addr_ff : 8'(addr_ff + 8'h01);

	// frame end clears the command state; sck may stop at any time
	always_ff @(posedge link_clk or posedge link_cs_n) begin
		if (link_cs_n) begin
			bit_cnt_ff <= FSC_BIT_FIRST;
			shift_ff <= 7'h00;
			phase_ff <= FSC_PH_OPC;
			opcode_ff <= FSC_ZERO_BYTE;
			addr_ff <= FSC_ZERO_BYTE;
			start_nv_ff <= 1'b0;
		end else begin
			bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
			shift_ff <= rx_byte[6:0];
			if (byte_end) begin
				unique case (phase_ff)
					FSC_PH_OPC: begin
						opcode_ff <= rx_byte;
						// legacy commands imply the primary byte address
						phase_ff <= rx_legacy ? FSC_PH_DAT : FSC_PH_ADR;
						addr_ff <= FSC_ADDR_STATUS1;
						start_nv_ff <= 1'b0;
					end
					FSC_PH_ADR: begin
						addr_ff <= rx_byte;
						start_nv_ff <= rx_byte[FSC_ADDR_NV_BIT];
						phase_ff <= FSC_PH_DAT;
					end
					FSC_PH_DAT: begin
						addr_ff <= addr_next;
					end
				endcase
			end
		end
	end

	// write hand-off; held past frame end so the core can pick it up
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_tgl_ff <= 1'b0;
			wr_addr_ff <= FSC_ZERO_BYTE;
			wr_data_ff <= FSC_ZERO_BYTE;
			wr_nv_ff <= 1'b0;
		end else if (data_byte_end && op_is_wr) begin
			wr_tgl_ff <= !wr_tgl_ff;
			wr_addr_ff <= addr_ff;
			wr_data_ff <= rx_byte;
			wr_nv_ff <= start_nv_ff;
		end
	end

	// ------------------------------------------------------------
	// link domain: read data out on the falling edge
	// ------------------------------------------------------------
	logic [39:0] img_ff;
	wire [7:0] img_b1 = img_ff[7:0];
	wire [7:0] img_b2 = img_ff[15:8];
	wire [7:0] img_b3 = img_ff[23:16];
	wire [7:0] img_b4 = img_ff[31:24];
	wire [7:0] img_drv = img_ff[39:32];
	wire rd_b1 = (addr_ff == FSC_ADDR_STATUS1);
	wire rd_b2 = (addr_ff == FSC_ADDR_STATUS2);
	wire rd_b3 = (addr_ff == FSC_ADDR_CTRL3);
	wire rd_b4 = (addr_ff == FSC_ADDR_CTRL4);
	wire rd_drv = (addr_ff == FSC_ADDR_DRIVE);
	// reserved and unmapped addresses read zero
	wire [7:0] rd_byte = rd_b1 ? img_b1 :
		rd_b2 ? img_b2 :
		rd_b3 ? img_b3 :
		rd_b4 ? img_b4 :
		rd_drv ? img_drv : FSC_ZERO_BYTE;
	wire rd_active = in_data && op_is_rd;

	always_ff @(negedge link_clk or posedge link_cs_n) begin
		if (link_cs_n) begin
			tx_ff <= FSC_ZERO_BYTE;
			miso_ff <= 1'b0;
			miso_oe_ff <= 1'b0;
		end else begin
			miso_oe_ff <= rd_active;
			if (bit_cnt_ff == FSC_BIT_FIRST) begin
				miso_ff <= rd_active && rd_byte[7];
				tx_ff <= {rd_byte[6:0], 1'b0};
			end else begin
				miso_ff <= rd_active && tx_ff[7];
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
		end
	end

	assign link_miso = miso_ff;
	assign link_miso_oe = miso_oe_ff;

	// ------------------------------------------------------------
	// core domain: synchronisers
	// ------------------------------------------------------------
	logic [2:0] cs_sync_ff;
	logic [2:0] wtg_sync_ff;
	logic [2:0] wp_sync_ff;
	logic link_idle_ff;
	logic wtg_seen_ff;
	logic wp_on_ff;

	wire cs_agree = (cs_sync_ff[1] == cs_sync_ff[2]);
	wire wp_agree = (wp_sync_ff[1] == wp_sync_ff[2]);
	wire wtg_agree = (wtg_sync_ff[1] == wtg_sync_ff[2]);
	wire wr_evt = wtg_agree && (wtg_sync_ff[2] != wtg_seen_ff);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cs_sync_ff <= 3'h7;
			wtg_sync_ff <= 3'h0;
			wp_sync_ff <= 3'h7;
			link_idle_ff <= 1'b1;
			wtg_seen_ff <= 1'b0;
			wp_on_ff <= 1'b0;
		end else begin
			cs_sync_ff <= {cs_sync_ff[1:0], link_cs_n};
			wtg_sync_ff <= {wtg_sync_ff[1:0], wr_tgl_ff};
			wp_sync_ff <= {wp_sync_ff[1:0], wp_n};
			if (cs_agree)
				link_idle_ff <= cs_sync_ff[2];
			if (wp_agree)
				wp_on_ff <= !wp_sync_ff[2];
			if (wr_evt)
				wtg_seen_ff <= wtg_sync_ff[2];
		end
	end

	// ------------------------------------------------------------
	// core domain: write decode
	// ------------------------------------------------------------
	wire grp_ok = (wr_addr_ff[FSC_ADDR_NV_BIT] == wr_nv_ff);
	wire wr_take = wr_evt && write_permit_latch && grp_ok;
	wire hit_b1 = wr_take && (wr_addr_ff == FSC_ADDR_STATUS1);
	wire hit_b2 = wr_take && (wr_addr_ff == FSC_ADDR_STATUS2);
	wire hit_b3 = wr_take && (wr_addr_ff == FSC_ADDR_CTRL3);
	wire hit_b4 = wr_take && (wr_addr_ff == FSC_ADDR_CTRL4);
	wire hit_drv = wr_take && wr_nv_ff && (wr_addr_ff == FSC_ADDR_DRIVE);
	wire lock_wr = wr_data_ff[FSC_B1_LOCK];
	// with the pin asserted the lock may only rise
	wire lock_keep = wp_on_ff && protection_map_lock && !lock_wr;
	wire nxt_lock = (hit_b1 && !lock_keep) ? lock_wr : protection_map_lock;

	logic lock_ff;
	logic [7:0] b2_ff;
	logic [7:0] b3_ff;
	logic [7:0] b4_ff;
	logic [7:0] drv_ff;
	logic done_ff;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			lock_ff <= FSC_LOCK_RST;
			b2_ff <= FSC_STATUS2_RST;
			b3_ff <= FSC_CTRL3_RST;
			b4_ff <= FSC_CTRL4_RST;
			drv_ff <= FSC_DRIVE_RST;
			done_ff <= 1'b0;
		end else begin
			lock_ff <= nxt_lock;
			if (hit_b2)
				b2_ff <= wr_data_ff;
			if (hit_b3)
				b3_ff <= wr_data_ff;
			if (hit_b4)
				b4_ff <= wr_data_ff;
			if (hit_drv)
				drv_ff <= wr_data_ff;
			done_ff <= wr_take;
		end
	end

	assign protection_map_lock = lock_ff;
	assign secondary_status_byte = b2_ff;
	assign third_status_control_byte = b3_ff;
	assign fourth_status_control_byte = b4_ff;
	assign output_drive_strength = drv_ff;
	assign status_write_done = done_ff;

	// ------------------------------------------------------------
	// core domain: program/erase fault
	// ------------------------------------------------------------
	logic fault_ff;
	logic retain_ff;

	// device reset spares the fault after automatic deepest sleep
	always_ff @(posedge core_clk) begin
		if (!power_up_rst_b) begin
			fault_ff <= 1'b0;
			retain_ff <= 1'b0;
		end else begin
			if (auto_deepest_entry)
				retain_ff <= 1'b1;
			else if (pe_done && rst_b)
				retain_ff <= 1'b0;
			if (!rst_b && !retain_ff)
				fault_ff <= 1'b0;
			else if (pe_done && rst_b)
				fault_ff <= pe_error;
		end
	end

	assign program_erase_fault = fault_ff;

	// ------------------------------------------------------------
	// core domain: read image
	// ------------------------------------------------------------
	wire [7:0] live_b1 = {lock_ff,
		deep_sleep_mode,
		fault_ff,
		deepest_sleep_mode,
		protection_summary,
		write_permit_latch,
		operation_in_progress};
	wire [7:0] shown_b1 = deepest_sleep_mode ? FSC_B1_DEEPEST_VAL : live_b1;

	// frozen during a frame: the link side reads it without a handshake,
	// so status seen by a poll is the value at frame start
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			img_ff <= {FSC_DRIVE_RST, FSC_CTRL4_RST, FSC_CTRL3_RST, FSC_STATUS2_RST,
				FSC_ZERO_BYTE};
		else if (link_idle_ff)
			img_ff <= {drv_ff, b4_ff, b3_ff, b2_ff, shown_b1};
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_lock_sticky;
		@(posedge core_clk) disable iff (!rst_b)
		lock_ff && wp_on_ff |=> lock_ff;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared under write protect");

	property p_lock_free;
		@(posedge core_clk) disable iff (!rst_b)
		hit_b1 && !wp_on_ff |=> lock_ff == $past(wr_data_ff[FSC_B1_LOCK]);
	endproperty
	a_lock_free: assert property (p_lock_free) else $error("lock did not take written bit");

	property p_no_latch;
		@(posedge core_clk) disable iff (!rst_b)
		wr_evt && !write_permit_latch |=> $stable(lock_ff) && $stable(b2_ff) && $stable(drv_ff);
	endproperty
	a_no_latch: assert property (p_no_latch) else $error("write taken with latch clear");

	property p_nv_only;
		@(posedge core_clk) disable iff (!rst_b)
		wr_evt && !wr_nv_ff |=> $stable(drv_ff);
	endproperty
	a_nv_only: assert property (p_nv_only) else $error("drive strength written from volatile group");

	property p_group;
		@(posedge core_clk) disable iff (!rst_b)
		wr_evt && !grp_ok |=> $stable(b2_ff) && $stable(b3_ff) && $stable(b4_ff) && $stable(lock_ff);
	endproperty
	a_group: assert property (p_group) else $error("write crossed register groups");

	property p_deepest;
		@(posedge core_clk) disable iff (!rst_b)
		link_idle_ff && deepest_sleep_mode |=> img_b1 == FSC_B1_DEEPEST_VAL;
	endproperty
	a_deepest: assert property (p_deepest) else $error("primary byte not all ones in deepest sleep");

	property p_busy;
		@(posedge core_clk) disable iff (!rst_b)
		link_idle_ff && !deepest_sleep_mode |=>
			img_b1[FSC_B1_BUSY] == $past(operation_in_progress) &&
			img_b1[FSC_B1_WPL] == $past(write_permit_latch);
	endproperty
	a_busy: assert property (p_busy) else $error("busy or latch copy wrong");

	property p_fault_keep;
		@(posedge core_clk) disable iff (!power_up_rst_b)
		retain_ff && !rst_b && !auto_deepest_entry ##0 fault_ff |=> fault_ff;
	endproperty
	a_fault_keep: assert property (p_fault_keep) else $error("fault lost across reset");

	property p_rsvd_zero;
		@(posedge link_clk) disable iff (link_cs_n)
		(addr_ff == FSC_ADDR_VOL_RSVD) || (addr_ff == FSC_ADDR_NV_RSVD) |-> rd_byte == FSC_ZERO_BYTE;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved address read non-zero");

endmodule : fsc_regs

`default_nettype wire

/* File: tb/fsc_host_model.sv */
// fsc_host_model: serial host that frames commands to the bank.
// assumes: mode 0, msb first; the clock runs only inside a frame.
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model (
	// serial link
	output logic link_clk,
	output logic link_cs_n,
	output logic link_mosi,
	input wire logic link_miso,
	input wire logic link_miso_oe
);
	import fsc_pkg::*;
	logic [7:0] tx [0:3];
	logic [7:0] rx [0:3];
	logic oe_seen;
	initial begin
		link_clk = 1'b0;
		link_cs_n = 1'b0;
		link_mosi = 1'b0;
		oe_seen = 1'b0;
		// a clean rising select clears the bank's frame state before use
		#5 link_cs_n = 1'b1;
	end
	// mosi moves while the clock is low, miso is taken at the rise
	task automatic byte_xfer(input logic [7:0] d, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			link_mosi = d[i];
			#40 link_clk = 1'b1;
			r[i] = link_miso;
			oe_seen = oe_seen | link_miso_oe;
			#80 link_clk = 1'b0;
			#40;
		end
	endtask : byte_xfer
	task automatic frame(input logic [7:0] op, input logic [7:0] adr, input int n);
		logic [7:0] dummy;
		oe_seen = 1'b0;
		link_cs_n = 1'b0;
		#50;
		byte_xfer(op, dummy);
		if (op == FSC_OP_RD_GENERIC || op == FSC_OP_WR_GENERIC) byte_xfer(adr, dummy);
		for (int k = 0; k < n; k++) byte_xfer(tx[k], rx[k]);
		#40 link_cs_n = 1'b1;
		// released line must not keep looking like data
		link_mosi = ~link_mosi;
		#400;
	endtask : frame
endmodule : fsc_host_model
`default_nettype wire

/* File: tb/fsc_regs_tb.sv */
// fsc_regs_tb: self-checking bench of the status/control bank.
// assumes: host model frames the commands; device state driven here.
`timescale 1ns/1ps
`default_nettype none
module fsc_regs_tb;
	import fsc_pkg::*;
	logic core_clk = 1'b0;
	// starts high: the first reset must give the link hand-off a falling edge
	logic rst_b = 1'b1, pwr_b = 1'b0, wpl = 1'b0, busy = 1'b0, dsl = 1'b0, dst = 1'b0;
	logic pe_done = 1'b0, pe_err = 1'b0, auto_en = 1'b0, wp_n = 1'b1;
	logic [1:0] psum = 2'b00;
	logic exp_lock = 1'b0, exp_fault = 1'b0;
	wire logic lclk, lcs_n, lmosi, lmiso, loe, lock, fault, done;
	wire logic [7:0] b2, b3, b4, drv;
	int failures = 0, checks = 0, dones = 0, cyc = 0;

	fsc_host_model h (.link_clk(lclk), .link_cs_n(lcs_n), .link_mosi(lmosi),
		.link_miso(lmiso), .link_miso_oe(loe));
	fsc_regs uut (.core_clk(core_clk), .rst_b(rst_b), .power_up_rst_b(pwr_b),
		.write_permit_latch(wpl), .operation_in_progress(busy), .deep_sleep_mode(dsl),
		.deepest_sleep_mode(dst), .protection_summary(psum), .pe_done(pe_done),
		.pe_error(pe_err), .auto_deepest_entry(auto_en), .wp_n(wp_n), .link_clk(lclk),
		.link_cs_n(lcs_n), .link_mosi(lmosi), .link_miso(lmiso), .link_miso_oe(loe),
		.protection_map_lock(lock), .program_erase_fault(fault),
		.secondary_status_byte(b2), .third_status_control_byte(b3),
		.fourth_status_control_byte(b4), .output_drive_strength(drv),
		.status_write_done(done));

	always #12.5 core_clk = ~core_clk;
	// run is some 4.4k cycles; the ceiling only cuts a hang
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (done === 1'b1) dones <= dones + 1;
		if (cyc == 60000) begin
			failures++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	function automatic logic [7:0] b1();
		return dst ? 8'hFF : {exp_lock, dsl, exp_fault, 1'b0, psum, wpl, busy};
	endfunction : b1
	task automatic setst(input logic w, b, d, u, input logic [1:0] s);
		@(posedge core_clk);
		wpl <= w;
		busy <= b;
		dsl <= d;
		dst <= u;
		psum <= s;
		repeat (4) @(posedge core_clk);
	endtask : setst
	task automatic pulse(input logic pd, er, au);
		@(posedge core_clk);
		pe_done <= pd;
		pe_err <= er;
		auto_en <= au;
		@(posedge core_clk);
		pe_done <= 1'b0;
		auto_en <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : pulse
	task automatic rst(input logic pwr);
		@(posedge core_clk);
		rst_b <= 1'b0;
		pwr_b <= ~pwr;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		pwr_b <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask : rst
	task automatic wr(input logic [7:0] op, adr, d0, d1, d2, input int n);
		h.tx[0] = d0;
		h.tx[1] = d1;
		h.tx[2] = d2;
		h.frame(op, adr, n);
	endtask : wr
	task automatic wl(input logic pin, input logic [7:0] d, input logic e);
		@(posedge core_clk);
		wp_n <= pin;
		repeat (6) @(posedge core_clk);
		wr(FSC_OP_WR_GENERIC, FSC_ADDR_STATUS1, d, 8'h00, 8'h00, 1);
		exp_lock = e;
		chk("lock_wp", lock, e);
	endtask : wl

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_map();
		setst(1, 1, 0, 0, 2'b11);
		h.frame(FSC_OP_RD_GENERIC, FSC_ADDR_VOL_RSVD, 4);
		chk("oe_rd", h.oe_seen, 1'b1);
		chk("rsvd0", h.rx[0], 8'h00);
		chk("byte1", h.rx[1], 8'h0F);
		chk("byte2", h.rx[2], 8'h00);
		chk("byte3", h.rx[3], 8'h00);
		for (int i = 0; i < 4; i++) begin
			if (i != 2) begin
				setst(i[0], ~i[0], 0, 0, i[1:0]);
				h.frame(FSC_OP_RD_STATUS1, 8'h00, 2);
				chk("st1", h.rx[0], b1());
				chk("st1_rep", h.rx[1], b1());
			end
		end
	endtask : t_map
	task automatic t_writes();
		int n;
		setst(1, 0, 0, 0, 2'b00);
		n = dones;
		wr(FSC_OP_WR_GENERIC, FSC_ADDR_STATUS2, 8'hA5, 8'h3C, 8'h96, 3);
		chk("b2", b2, 8'hA5);
		chk("b3", b3, 8'h3C);
		chk("b4", b4, 8'h96);
		chk("dones", 8'(dones - n), 8'h03);
		h.frame(FSC_OP_RD_GENERIC, FSC_ADDR_CTRL3, 2);
		chk("rd3", h.rx[0], 8'h3C);
		chk("rd4", h.rx[1], 8'h96);
		wr(FSC_OP_WR_GENERIC, FSC_ADDR_DRIVE, 8'h5A, 8'h00, 8'h00, 1);
		chk("drv", drv, 8'h5A);
		// starts volatile and runs into the non-volatile group
		wr(FSC_OP_WR_GENERIC, 8'h7F, 8'h00, 8'h00, 8'hC3, 3);
		chk("drv_kept", drv, 8'h5A);
		h.frame(FSC_OP_RD_GENERIC, FSC_ADDR_NV_RSVD, 2);
		chk("rsvd80", h.rx[0], 8'h00);
		chk("rd81", h.rx[1], 8'h5A);
		n = dones;
		// all ones on purpose: read-only bits must ignore them
		wr(FSC_OP_WR_STATUS, 8'h00, 8'hFF, 8'h33, 8'h00, 2);
		exp_lock = 1'b1;
		chk("lock", lock, 1'b1);
		chk("b2_legacy", b2, 8'h33);
		chk("dones", 8'(dones - n), 8'h02);
		h.frame(FSC_OP_RD_STATUS1, 8'h00, 1);
		chk("st1_after", h.rx[0], b1());
	endtask : t_writes
	task automatic t_guard();
		int n;
		wl(1'b0, 8'h00, 1'b1);
		wl(1'b1, 8'h00, 1'b0);
		wl(1'b0, 8'h80, 1'b1);
		wl(1'b1, 8'h00, 1'b0);
		setst(0, 0, 0, 0, 2'b00);
		n = dones;
		wr(FSC_OP_WR_GENERIC, FSC_ADDR_STATUS2, 8'h77, 8'h00, 8'h00, 1);
		wr(FSC_OP_WR_STATUS, 8'h00, 8'h80, 8'h11, 8'h00, 2);
		chk("b2_locked", b2, 8'h33);
		chk("lock_locked", lock, 1'b0);
		chk("dones", 8'(dones - n), 8'h00);
		h.frame(8'hAB, 8'h00, 2);
		chk("oe_unknown", h.oe_seen, 1'b0);
	endtask : t_guard
	task automatic t_sleep();
		setst(0, 0, 1, 0, 2'b11);
		h.frame(FSC_OP_RD_STATUS1, 8'h00, 1);
		chk("deep", h.rx[0], 8'h4C);
		setst(0, 0, 1, 1, 2'b11);
		h.frame(FSC_OP_RD_GENERIC, FSC_ADDR_STATUS1, 1);
		chk("deepest", h.rx[0], 8'hFF);
		setst(1, 0, 0, 0, 2'b00);
	endtask : t_sleep
	task automatic t_fault();
		pulse(1, 1, 0);
		exp_fault = 1'b1;
		h.frame(FSC_OP_RD_STATUS1, 8'h00, 1);
		chk("fault_rd", h.rx[0], b1());
		pulse(1, 0, 0);
		chk("fault_ok", fault, 1'b0);
		pulse(1, 1, 0);
		pulse(0, 0, 1);
		rst(1'b0);
		chk("fault_kept", fault, 1'b1);
		h.frame(FSC_OP_RD_STATUS1, 8'h00, 1);
		chk("kept_rd", h.rx[0], b1());
		rst(1'b1);
		exp_fault = 1'b0;
		chk("fault_pwr", fault, 1'b0);
		chk("b2_pwr", b2, 8'h00);
		wr(FSC_OP_WR_GENERIC, FSC_ADDR_STATUS2, 8'h33, 8'h00, 8'h00, 1);
		chk("b2_again", b2, 8'h33);
	endtask : t_fault

	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude

	initial begin
		rst(1'b1);
		t_map();
		t_writes();
		t_guard();
		t_sleep();
		t_fault();
		conclude();
	end
endmodule : fsc_regs_tb
`default_nettype wire
